// file: common/modem_cfg.svh
// offsets, field positions and reset values of the modem pin block
// assumes a byte-addressed register bus with one aligned word per register
`ifndef MODEM_CFG_SVH
`define MODEM_CFG_SVH

// register byte offsets
`define MODEM_OFF_PRI    8'h00
`define MODEM_OFF_SEC    8'h04
`define MODEM_OFF_STRAP  8'h08

// modem control field positions
`define MCR_DTR_BIT      0
`define MCR_RTS_BIT      1
`define MCR_LOOP_BIT     4
`define MCR_IR_BIT       5

// writable bits and reset value of a modem control register
`define MCR_WMASK        8'h33
`define MCR_RESET        8'h00

// latched strap set after a reset outside adapter mode, all clear
`define STRAP_RESET      5'h00

// bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// file: common/modem_pkg.sv
// types shared by the modem pin block
// assumes modem_cfg.svh for all numeric values
package modem_pkg;

    // strap set as latched at the end of reset
    typedef struct packed {
        logic       adapter;
        logic       disk_en;
        logic       uart_b;
        logic [1:0] parport;
    } strap_s;

    typedef logic [1:0] resp_t;

endpackage

// file: common/modem_ctl_if.sv
// control bits and pin levels between the register file and one port's handshake logic
// assumes both ends on the same clock
`timescale 1ns/1ns
`default_nettype none
interface modem_ctl_if;
    logic dtr_bit;
    logic rts_bit;
    logic loop;
    logic tx_data;
    logic send_request_n;
    logic terminal_ready_n;
    logic serial_out;

    modport ctl (output dtr_bit, output rts_bit, output loop, output tx_data,
                 input send_request_n, input terminal_ready_n, input serial_out);
    modport hs  (input dtr_bit, input rts_bit, input loop, input tx_data,
                 output send_request_n, output terminal_ready_n, output serial_out);
endinterface
`default_nettype wire

// file: rtl/pin_sync.sv
// three-stage synchroniser for a group of pin inputs
// assumes the pins are asynchronous to aclk; no reset, so straps can be sampled in reset
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // s1 feeds s2 only; metastability stays inside the chain
    always_ff @(posedge aclk)
    begin
        s1 <= d;
        s2 <= s1;
        s3 <= s2;
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge aclk)
    begin
        for (int i = 0; i < W; i++)
        begin
            if (s2[i] == s3[i])
                q[i] <= s3[i];
        end
    end
endmodule
`default_nettype wire

// file: rtl/port_handshake.sv
// modem handshake outputs of one serial port
// assumes control bits arrive from a register file on the same clock
`timescale 1ns/1ns
`default_nettype none
module port_handshake (
    input  wire logic aclk,
    input  wire logic aresetn,
    modem_ctl_if.hs   ctl
);
    // outputs registered; reset and loopback both force the idle high level
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctl.send_request_n   <= 1'b1;
            ctl.terminal_ready_n <= 1'b1;
            ctl.serial_out       <= 1'b1;
        end
        else if (ctl.loop)
        begin
            ctl.send_request_n   <= 1'b1;
            ctl.terminal_ready_n <= 1'b1;
            ctl.serial_out       <= 1'b1;
        end
        else
        begin
            ctl.send_request_n   <= ~ctl.rts_bit;
            ctl.terminal_ready_n <= ~ctl.dtr_bit;
            ctl.serial_out       <= ctl.tx_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    rts_follow_a: assert property (!ctl.loop && ctl.rts_bit |=> !ctl.send_request_n)
        else $error("send request not asserted for set bit");
    rts_idle_a: assert property (!ctl.rts_bit |=> ctl.send_request_n)
        else $error("send request asserted for clear bit");
    // reset checks must not be switched off by the reset they watch
    rts_reset_a: assert property (@(posedge aclk) disable iff (1'b0)
                                  !aresetn |=> ctl.send_request_n)
        else $error("send request active after reset");
    rts_loop_a: assert property (ctl.loop |=> ctl.send_request_n)
        else $error("send request active in loopback");
    dtr_follow_a: assert property (!ctl.loop && ctl.dtr_bit |=> !ctl.terminal_ready_n)
        else $error("terminal ready not asserted for set bit");
    dtr_reset_a: assert property (@(posedge aclk) disable iff (1'b0)
                                  !aresetn |=> ctl.terminal_ready_n)
        else $error("terminal ready active after reset");
    dtr_loop_a: assert property (ctl.loop |=> ctl.terminal_ready_n)
        else $error("terminal ready active in loopback");
endmodule
`default_nettype wire

// file: rtl/modem_pins.sv
// modem handshake pins of two serial ports, with adapter-mode straps on the shared pins
// assumes an AXI4-Lite master on aclk and pins asynchronous to aclk
`timescale 1ns/1ns
`include "modem_cfg.svh"
`default_nettype none
module modem_pins (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // register bus
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    // board and core side
    input  wire logic        adapter_mode_pin,
    input  wire logic        primary_tx_data,
    input  wire logic        secondary_tx_data,
    // shared pins as input, output and low-active enable; secondary ready and serial out are output only
    input  wire logic        primary_serial_out_i,
    output var  logic        primary_serial_out_o,
    output var  logic        primary_serial_out_oe_n,
    input  wire logic        primary_send_request_n_i,
    output var  logic        primary_send_request_n_o,
    output var  logic        primary_send_request_n_oe_n,
    input  wire logic        primary_terminal_ready_n_i,
    output var  logic        primary_terminal_ready_n_o,
    output var  logic        primary_terminal_ready_n_oe_n,
    input  wire logic        secondary_send_request_n_i,
    output var  logic        secondary_send_request_n_o,
    output var  logic        secondary_send_request_n_oe_n,
    output var  logic        secondary_terminal_ready_n,
    output var  logic        secondary_serial_out,
    // receive pins and their routed data
    input  wire logic        primary_serial_in,
    input  wire logic        secondary_serial_or_ir_in,
    output var  logic        primary_rx_data,
    output var  logic        secondary_wired_rx_data,
    output var  logic        secondary_ir_rx_data,
    // latched configuration
    output var  logic [1:0]  parport_addr_sel,
    output var  logic        uart_b_addr_sel,
    output var  logic        disk_iface_enable
);
    modem_ctl_if pri_if ();
    modem_ctl_if sec_if ();

    logic [7:0]       pri_mcr;
    logic [7:0]       sec_mcr;
    modem_pkg::strap_s straps;
    logic [6:0]       pins_raw;
    logic [6:0]       pins;
    logic             aw_held;
    logic             w_held;
    logic [7:0]       aw_addr_q;
    logic [7:0]       w_data_q;
    logic             w_lane0_q;
    logic             release_pins;
    logic             ir_sel;

    ////////////////////////////////////////////////////////////////////////////////
    // synchronise straps, mode pin and receive pins
    assign pins_raw = {secondary_serial_or_ir_in, primary_serial_in, adapter_mode_pin,
                       primary_terminal_ready_n_i, secondary_send_request_n_i,
                       primary_send_request_n_i, primary_serial_out_i};

    pin_sync #(
        .W (7)
    ) u_sync (
        .aclk (aclk),
        .d    (pins_raw),
        .q    (pins)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // strap capture: follow the pins while in reset (only the mode strap outside adapter mode), frozen from the release edge on;
    // relies on the board holding each strap steady through reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            straps.adapter <= pins[4];
            if (pins[4])
            begin
                straps.parport <= {pins[1], pins[0]};
                straps.uart_b  <= pins[2];
                straps.disk_en <= pins[3];
            end
            else
            begin
                straps.parport <= 2'h0;
                straps.uart_b  <= 1'b0;
                straps.disk_en <= 1'b0;
            end
        end
    end

    assign parport_addr_sel  = straps.parport;
    assign uart_b_addr_sel   = straps.uart_b;
    assign disk_iface_enable = straps.disk_en;

    // shared pins let go during reset in adapter mode, so the board straps can be read
    assign release_pins = !aresetn && pins[4];

    assign primary_serial_out_oe_n       = release_pins;
    assign primary_send_request_n_oe_n   = release_pins;
    assign primary_terminal_ready_n_oe_n = release_pins;
    assign secondary_send_request_n_oe_n = release_pins;

    ////////////////////////////////////////////////////////////////////////////////
    // handshake logic of both ports
    assign pri_if.dtr_bit = pri_mcr[`MCR_DTR_BIT];
    assign pri_if.rts_bit = pri_mcr[`MCR_RTS_BIT];
    assign pri_if.loop    = pri_mcr[`MCR_LOOP_BIT];
    assign pri_if.tx_data = primary_tx_data;
    assign sec_if.dtr_bit = sec_mcr[`MCR_DTR_BIT];
    assign sec_if.rts_bit = sec_mcr[`MCR_RTS_BIT];
    assign sec_if.loop    = sec_mcr[`MCR_LOOP_BIT];
    assign sec_if.tx_data = secondary_tx_data;

    port_handshake u_pri (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ctl     (pri_if.hs)
    );

    port_handshake u_sec (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ctl     (sec_if.hs)
    );

    assign primary_serial_out_o       = pri_if.serial_out;
    assign primary_send_request_n_o   = pri_if.send_request_n;
    assign primary_terminal_ready_n_o = pri_if.terminal_ready_n;
    assign secondary_send_request_n_o = sec_if.send_request_n;
    assign secondary_terminal_ready_n = sec_if.terminal_ready_n;
    assign secondary_serial_out       = sec_if.serial_out;

    ////////////////////////////////////////////////////////////////////////////////
    // receive routing; the unused path idles high like a quiet line
    assign ir_sel = sec_mcr[`MCR_IR_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            primary_rx_data         <= 1'b1;
            secondary_wired_rx_data <= 1'b1;
            secondary_ir_rx_data    <= 1'b1;
        end
        else
        begin
            primary_rx_data         <= pins[5];
            secondary_wired_rx_data <= ir_sel ? 1'b1 : pins[6];
            secondary_ir_rx_data    <= ir_sel ? pins[6] : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write channel: address and data held separately, answered once both are in
    assign awready = !aw_held && !bvalid;
    assign wready  = !w_held && !bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 8'h00;
            w_lane0_q <= 1'b0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held   <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held    <= 1'b1;
                w_data_q  <= wdata[7:0];
                w_lane0_q <= wstrb[0];
            end
            if (aw_held && w_held)
            begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end
        end
    end

    // control registers; only byte lane 0 carries writable bits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pri_mcr <= `MCR_RESET;
            sec_mcr <= `MCR_RESET;
        end
        else if (aw_held && w_held && w_lane0_q)
        begin
            if (aw_addr_q == `MODEM_OFF_PRI)
                pri_mcr <= w_data_q & `MCR_WMASK;
            if (aw_addr_q == `MODEM_OFF_SEC)
                sec_mcr <= w_data_q & `MCR_WMASK;
        end
    end

    // write response; the strap register ignores writes but answers OKAY
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp  <= `RESP_OKAY;
        end
        else if (aw_held && w_held)
        begin
            bvalid <= 1'b1;
            if (aw_addr_q == `MODEM_OFF_PRI || aw_addr_q == `MODEM_OFF_SEC ||
                aw_addr_q == `MODEM_OFF_STRAP)
                bresp <= `RESP_OKAY;
            else
                bresp <= `RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read channel, one cycle to answer
    assign arready = !rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rresp  <= `RESP_OKAY;
            case (araddr)
                `MODEM_OFF_PRI:   rdata <= {24'h00_0000, pri_mcr};
                `MODEM_OFF_SEC:   rdata <= {24'h00_0000, sec_mcr};
                `MODEM_OFF_STRAP: rdata <= {27'h000_0000, straps};
                default:
                begin
                    rdata <= 32'h0000_0000;
                    rresp <= `RESP_SLVERR;
                end
            endcase
        end
        else if (rready)
        begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking

    // synchronised straps stay unknown until the chain has filled, so the latch
    // checks wait for five reset cycles in adapter mode before trusting them
    sequence strap_settled;
        (!aresetn && pins[4]) [*5];
    endsequence

    sequence held_run;
        aresetn [*2];
    endsequence

    strap_capture_a: assert property (strap_settled ##1 aresetn |->
                                      straps == {1'b1, $past(pins[3:0])})
        else $error("straps not taken from the last reset cycle");
    strap_hold_a: assert property (held_run |-> $stable(straps))
        else $error("latched straps changed outside reset");
    parport_latch_a: assert property (strap_settled |=> parport_addr_sel ==
                                      $past({pins[1], pins[0]}))
        else $error("parallel port straps not latched");
    uart_b_latch_a: assert property (strap_settled |=> uart_b_addr_sel ==
                                     $past(pins[2]))
        else $error("secondary serial strap not latched");
    disk_latch_a: assert property (strap_settled |=> disk_iface_enable ==
                                   $past(pins[3]))
        else $error("disk interface strap not latched");
    pins_drive_a: assert property (aresetn |-> !primary_send_request_n_oe_n &&
                                   !primary_terminal_ready_n_oe_n && !primary_serial_out_oe_n)
        else $error("shared pin not driven after reset");
    ir_route_a: assert property (disable iff (!aresetn)
                                 ir_sel && aresetn ##1 aresetn |-> secondary_wired_rx_data)
        else $error("wired receive active in infrared mode");
    ir_off_a: assert property (disable iff (!aresetn)
                               !ir_sel && aresetn ##1 aresetn |-> secondary_ir_rx_data)
        else $error("infrared receive active in wired mode");

    // shared pins must be let go while the board straps are read
    pins_release_a: assert property (!aresetn && pins[4] |-> primary_send_request_n_oe_n &&
                                     secondary_send_request_n_oe_n &&
                                     primary_terminal_ready_n_oe_n && primary_serial_out_oe_n)
        else $error("shared pin driven while straps are read");

    // bus answers come one cycle after the request is complete
    write_answer_a: assert property (disable iff (!aresetn) aw_held && w_held |=> bvalid)
        else $error("write response missing");
    read_answer_a: assert property (disable iff (!aresetn) arvalid && arready |=> rvalid)
        else $error("read answer missing");
    lane_skip_a: assert property (disable iff (!aresetn) aw_held && w_held && !w_lane0_q |=>
                                  $stable(pri_mcr) && $stable(sec_mcr))
        else $error("control bits changed without byte lane 0");
endmodule
`default_nettype wire

// file: verif/modem_partner.sv
// board and modem model at the far side of the handshake and strap pins
// assumes low-active output enables from the block and a strap resistor on every shared pin
`timescale 1ns/1ns
`default_nettype none
module modem_partner (
    input  wire logic [3:0] pin_o,
    input  wire logic [3:0] pin_oe_n,
    input  wire logic [3:0] strap_level,
    input  wire logic       rx_pri_level,
    input  wire logic       rx_sec_level,
    output var  logic [3:0] pin_wire,
    output var  logic       primary_serial_in,
    output var  logic       secondary_serial_or_ir_in
);
    // a released pin falls to its strap resistor, which the board holds through reset
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            pin_wire[i] = pin_oe_n[i] ? strap_level[i] : pin_o[i];
    end

    // modem drives both receive lines at the levels the bench commands
    assign primary_serial_in = rx_pri_level;
    assign secondary_serial_or_ir_in = rx_sec_level;
endmodule
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for the modem pin block, register access over AXI4-Lite
// assumes modem_partner.sv for the board side; pin index 0 primary out, 1/2 send requests, 3 ready
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("ERROR %0t mismatch got %h exp %h", $time, got, exp); \
        end \
    end
module testbench;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, adapter, rx_pri, rx_sec, pri_in, sec_in;
    logic        p_rx, s_wired, s_ir, s_dtr_n, s_out, ub_sel, disk_en, rts, dtr, sout;
    logic [7:0]  awaddr, araddr, v;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb, strap;
    logic [1:0]  bresp, rresp, resp, pp_sel;
    wire  [3:0]  pin_o, pin_oe_n, pin_w;
    int          n_errors, check_count;
    localparam logic [7:0] mcr_vals [5] = '{8'h02, 8'h01, 8'h03, 8'h13, 8'h00};

    modem_pins i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .adapter_mode_pin(adapter), .primary_tx_data(1'b0), .secondary_tx_data(1'b0),
        .primary_serial_out_i(pin_w[0]), .primary_serial_out_o(pin_o[0]),
        .primary_serial_out_oe_n(pin_oe_n[0]), .primary_send_request_n_i(pin_w[1]),
        .primary_send_request_n_o(pin_o[1]), .primary_send_request_n_oe_n(pin_oe_n[1]),
        .primary_terminal_ready_n_i(pin_w[3]), .primary_terminal_ready_n_o(pin_o[3]),
        .primary_terminal_ready_n_oe_n(pin_oe_n[3]), .secondary_send_request_n_i(pin_w[2]),
        .secondary_send_request_n_o(pin_o[2]), .secondary_send_request_n_oe_n(pin_oe_n[2]),
        .secondary_terminal_ready_n(s_dtr_n), .secondary_serial_out(s_out),
        .primary_serial_in(pri_in), .secondary_serial_or_ir_in(sec_in),
        .primary_rx_data(p_rx), .secondary_wired_rx_data(s_wired),
        .secondary_ir_rx_data(s_ir), .parport_addr_sel(pp_sel), .uart_b_addr_sel(ub_sel),
        .disk_iface_enable(disk_en));

    modem_partner i_board (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .strap_level(strap),
        .rx_pri_level(rx_pri), .rx_sec_level(rx_sec), .pin_wire(pin_w),
        .primary_serial_in(pri_in), .secondary_serial_or_ir_in(sec_in));

    // free-running 50 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // a wait that runs out of its bound ends the run as a mismatch
    task automatic give_up();
        n_errors++;
        $display("ERROR %0t bus answer never came", $time);
        tally_and_finish();
    endtask

    // let the edge's updates land before looking at outputs
    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    // address and data offered together, each released when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int   i;
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge aclk);
            if (bvalid && aw_ok && w_ok)
                break;
            if (!aw_ok && awready)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        if (i == 40)
            give_up();
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge aclk);
            if (rvalid && !arvalid)
                break;
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        if (i == 40)
            give_up();
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: straps, handshake table, register map, receive routing, late reset
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
        {adapter, strap, rx_pri, rx_sec, aresetn} = {1'b1, 4'b1101, 3'b110};
        n_errors = 0;
        check_count = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // reset again long enough for the strap synchronisers
        aresetn <= 1'b0;
        settle(8);
        `CHK(pin_oe_n, 4'hf)
        `CHK(pin_o[3:1], 3'b111)
        @(posedge aclk);
        aresetn <= 1'b1;
        settle(1);
        `CHK(pin_oe_n, 4'h0)
        `CHK({disk_en, ub_sel, pp_sel}, 4'b1101)
        strap <= 4'b0010;
        axi_read(8'h08);
        `CHK(rd, 32'h0000_001d)
        `CHK({disk_en, ub_sel, pp_sel}, 4'b1101)
        // five control values on both ports; transmit data held low
        for (int p = 0; p < 2; p++)
            for (int k = 0; k < 5; k++)
            begin
                v = mcr_vals[k];
                axi_write(p ? 8'h04 : 8'h00, {24'h0, v});
                settle(2);
                rts = p ? pin_o[2] : pin_o[1];
                dtr = p ? s_dtr_n : pin_o[3];
                sout = p ? s_out : pin_o[0];
                `CHK(resp, 2'h0)
                `CHK(rts, ~(v[1] & ~v[4]))
                `CHK(dtr, ~(v[0] & ~v[4]))
                `CHK(sout, v[4])
            end
        // masked readback, read-only strap word, unmapped place
        axi_write(8'h00, 32'hffff_ffff);
        axi_read(8'h00);
        `CHK(rd, 32'h0000_0033)
        // a write without byte lane 0 leaves the control bits alone
        wstrb <= 4'he;
        axi_write(8'h00, 32'h0000_0000);
        wstrb <= 4'hf;
        axi_read(8'h00);
        `CHK(rd, 32'h0000_0033)
        axi_write(8'h08, 32'h0000_0000);
        `CHK(resp, 2'h0)
        axi_read(8'h08);
        `CHK(rd, 32'h0000_001d)
        axi_write(8'h0c, 32'h0000_0001);
        `CHK(resp, 2'h2)
        axi_read(8'h0c);
        `CHK({resp, rd}, {2'h2, 32'h0})
        // secondary receive pin routed by the infrared select bit
        rx_pri <= 1'b0;
        rx_sec <= 1'b0;
        axi_write(8'h04, 32'h0000_0020);
        settle(8);
        `CHK({p_rx, s_wired, s_ir}, 3'b010)
        axi_write(8'h04, 32'h0000_0000);
        settle(8);
        `CHK({s_wired, s_ir}, 2'b01)
        // third reset out of non-adapter mode with both pins asserted
        axi_write(8'h00, 32'h0000_0003);
        adapter <= 1'b0;
        aresetn <= 1'b0;
        settle(1);
        `CHK(pin_o[3:1], 3'b111)
        settle(7);
        `CHK(pin_oe_n, 4'h0)
        @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(8'h00);
        `CHK(rd, 32'h0)
        axi_read(8'h08);
        `CHK(rd, 32'h0)
        `CHK({disk_en, ub_sel, pp_sel}, 4'b0000)
        tally_and_finish();
    end
endmodule
`default_nettype wire
